/* File: core/cdx_alu.sv */
// Combinational decode and arithmetic for the two file-register operations
`timescale 1ns/1ps
module cdx_alu
(
	input  wire logic [13:0]     insn,
	input  wire logic [7:0]      operand,
	output cdx_pkg::cdx_op_t     op,
	output logic      [7:0]      result,
	output logic                 result_zero
);
	logic [5:0] opc;

	always_comb
	begin
		opc = insn[cdx_pkg::OPC_MSB:cdx_pkg::OPC_LSB];
		op = cdx_pkg::CDX_OP_NONE;
		result = operand;
		if (opc == cdx_pkg::OPC_INVERT)
		begin
			op = cdx_pkg::CDX_OP_INVERT;
			result = ~operand;
		end
		else if (opc == cdx_pkg::OPC_DECR)
		begin
			op = cdx_pkg::CDX_OP_DECR;
			result = operand - cdx_pkg::DATA_ONE;
		end
		result_zero = (result == cdx_pkg::DATA_ZERO);
	end
endmodule : cdx_alu

/* File: core/cdx_exec.sv */
// Execution slice for invert_file_op and decrement_file_op
`timescale 1ns/1ps
module cdx_exec
(
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic        insn_valid,
	input  wire logic [13:0] insn,
	output logic      [6:0]  file_raddr,
	input  wire logic [7:0]  file_rdata,
	output logic             file_we,
	output logic      [6:0]  file_waddr,
	output logic      [7:0]  file_wdata,
	output logic      [7:0]  acc,
	output logic      [7:0]  status,
	output logic             op_done
);
	cdx_pkg::cdx_op_t op;
	logic [7:0]       result;
	logic             result_zero;
	logic             hit;
	logic             dest_file;

	logic [7:0] acc_reg, acc_next;
	logic [7:0] status_reg, status_next;
	logic       file_we_reg, file_we_next;
	logic [6:0] file_waddr_reg, file_waddr_next;
	logic [7:0] file_wdata_reg, file_wdata_next;
	logic       done_reg, done_next;

	// Operand is read combinationally so the whole operation fits one cycle
	assign file_raddr = insn[cdx_pkg::ADDR_W-1:0];
	assign dest_file  = insn[cdx_pkg::DEST_BIT];

	// Limitation: a write lands one edge after the taking edge, so an operation on the
	// same address in the very next cycle needs a bypass outside this block
	cdx_alu u_alu
	(
		.insn        (insn),
		.operand     (file_rdata),
		.op          (op),
		.result      (result),
		.result_zero (result_zero)
	);

	// Opcodes outside the two are ignored even when issued, so no partial state is left
	assign hit = insn_valid && (op != cdx_pkg::CDX_OP_NONE);

	always_comb
	begin
		acc_next        = acc_reg;
		status_next     = status_reg;
		file_we_next    = 1'b0;
		file_waddr_next = file_waddr_reg;
		file_wdata_next = file_wdata_reg;
		done_next       = hit;
		if (hit)
		begin
			// Only the zero bit changes; other flags belong to other operations
			status_next[cdx_pkg::STAT_ZBIT] = result_zero;
			if (dest_file)
			begin
				file_we_next    = 1'b1;
				file_waddr_next = file_raddr;
				file_wdata_next = result;
			end
			else
			begin
				acc_next = result;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			acc_reg        <= cdx_pkg::ACC_RESET;
			status_reg     <= cdx_pkg::STAT_RESET;
			file_we_reg    <= 1'b0;
			file_waddr_reg <= 7'h00;
			file_wdata_reg <= 8'h00;
			done_reg       <= 1'b0;
		end
		else
		begin
			acc_reg        <= acc_next;
			status_reg     <= status_next;
			file_we_reg    <= file_we_next;
			file_waddr_reg <= file_waddr_next;
			file_wdata_reg <= file_wdata_next;
			done_reg       <= done_next;
		end
	end

	// Write address and data keep their last values; only the strobe marks a new write
	assign acc        = acc_reg;
	assign status     = status_reg;
	assign file_we    = file_we_reg;
	assign file_waddr = file_waddr_reg;
	assign file_wdata = file_wdata_reg;
	assign op_done    = done_reg;

	// Each issue is the taking edge; its results show one edge later
	sequence inv_issue_s;
		insn_valid && insn[cdx_pkg::OPC_MSB:cdx_pkg::OPC_LSB] == cdx_pkg::OPC_INVERT;
	endsequence

	sequence dec_issue_s;
		insn_valid && insn[cdx_pkg::OPC_MSB:cdx_pkg::OPC_LSB] == cdx_pkg::OPC_DECR;
	endsequence

	sequence file_issue_s;
		hit && insn[cdx_pkg::DEST_BIT];
	endsequence

	sequence acc_issue_s;
		hit && !insn[cdx_pkg::DEST_BIT];
	endsequence

	invert_value_a: assert property (@(posedge clk) disable iff (srst)
		inv_issue_s ##0 !insn[7] |=> acc == ~$past(file_rdata))
		else $error("invert result wrong");

	invert_decode_a: assert property (@(posedge clk) disable iff (srst)
		inv_issue_s |=> op_done)
		else $error("invert not recognised");

	decr_value_a: assert property (@(posedge clk) disable iff (srst)
		dec_issue_s ##0 insn[7] |=> file_wdata == 8'($past(file_rdata) - 8'h01))
		else $error("decrement result wrong");

	decr_decode_a: assert property (@(posedge clk) disable iff (srst)
		dec_issue_s |=> op_done)
		else $error("decrement not recognised");

	acc_dest_a: assert property (@(posedge clk) disable iff (srst)
		hit && !insn[7] |=> !file_we)
		else $error("file written with dest clear");

	file_dest_a: assert property (@(posedge clk) disable iff (srst)
		hit && insn[7] |=> file_we && acc == $past(acc))
		else $error("file dest wrong");

	addr_field_a: assert property (@(posedge clk) disable iff (srst)
		hit && insn[7] |=> file_waddr == $past(insn[6:0]))
		else $error("write address wrong");

	other_flags_a: assert property (@(posedge clk) disable iff (srst)
		##1 (status & 8'hfb) == ($past(status) & 8'hfb))
		else $error("non-zero flag changed");

	// Reset can land on a cycle with an issue pending; that issue is dropped, not finished
	one_cycle_a: assert property (@(posedge clk) disable iff (srst)
		op_done == ($past(hit) && !$past(srst)))
		else $error("operation not single cycle");

	zero_flag_a: assert property (@(posedge clk) disable iff (srst)
		hit |=> status[cdx_pkg::STAT_ZBIT] ==
			(file_we ? (file_wdata == 8'h00) : (acc == 8'h00)))
		else $error("zero flag wrong");

	invert_file_a: assert property (@(posedge clk) disable iff (srst)
		inv_issue_s ##0 file_issue_s |=> file_wdata == ~$past(file_rdata))
		else $error("invert file result wrong");

	decr_acc_a: assert property (@(posedge clk) disable iff (srst)
		dec_issue_s ##0 acc_issue_s |=> acc == 8'($past(file_rdata) - 8'h01))
		else $error("decrement accumulator result wrong");

	refuse_quiet_a: assert property (@(posedge clk) disable iff (srst)
		!hit |=> !op_done && !file_we)
		else $error("pulse without an accepted operation");

	// Accumulator and status may only move, and the write strobe only be high, in answer to an accepted operation
	acc_source_a: assert property (@(posedge clk) disable iff (srst)
		!$stable(acc) && !$past(srst) |-> $past(hit && !insn[cdx_pkg::DEST_BIT]))
		else $error("accumulator moved without an operation");

	write_source_a: assert property (@(posedge clk) disable iff (srst)
		file_we |-> $past(hit && insn[cdx_pkg::DEST_BIT]))
		else $error("file write without an operation");

	status_source_a: assert property (@(posedge clk) disable iff (srst)
		!$stable(status) && !$past(srst) |-> $past(hit))
		else $error("status moved without an operation");

	write_hold_a: assert property (@(posedge clk) disable iff (srst)
		!hit |=> $stable(file_waddr) && $stable(file_wdata))
		else $error("write address or data moved while idle");

	read_addr_a: assert property (@(posedge clk) disable iff (srst)
		file_raddr == insn[cdx_pkg::ADDR_W-1:0])
		else $error("read address not taken from the instruction");

	reset_state_a: assert property (@(posedge clk) disable iff (srst)
		$past(srst) |-> acc == cdx_pkg::ACC_RESET && status == cdx_pkg::STAT_RESET
			&& !file_we && !op_done)
		else $error("outputs not at reset values");

	invert_zero_a: assert property (@(posedge clk) disable iff (srst)
		inv_issue_s ##0 file_rdata == 8'hff |=> status[cdx_pkg::STAT_ZBIT])
		else $error("zero flag missed after invert");

	decr_zero_a: assert property (@(posedge clk) disable iff (srst)
		dec_issue_s ##0 file_rdata == 8'h01 |=> status[cdx_pkg::STAT_ZBIT])
		else $error("zero flag missed after decrement");

	back_to_back_a: assert property (@(posedge clk) disable iff (srst)
		hit ##1 hit |=> op_done && $past(op_done))
		else $error("back to back operations lost a cycle");
endmodule : cdx_exec

/* File: core/cdx_pkg.sv */
// Constants for the complement and decrement execution slice
package cdx_pkg;
	localparam int unsigned INSN_W      = 14;
	localparam int unsigned DATA_W      = 8;
	localparam int unsigned ADDR_W      = 7;
	localparam int unsigned OPC_MSB     = 13;
	localparam int unsigned OPC_LSB     = 8;
	localparam int unsigned DEST_BIT    = 7;
	localparam logic [5:0]  OPC_INVERT  = 6'h09;
	localparam logic [5:0]  OPC_DECR    = 6'h03;
	localparam logic [7:0]  DATA_ONE    = 8'h01;
	localparam logic [7:0]  DATA_ZERO   = 8'h00;
	localparam logic [7:0]  ACC_RESET   = 8'h00;
	localparam int unsigned STAT_ZBIT   = 2;
	localparam logic [7:0]  STAT_RESET  = 8'h18;
	typedef enum logic [1:0] {CDX_OP_NONE, CDX_OP_INVERT, CDX_OP_DECR} cdx_op_t;
endpackage : cdx_pkg

/* File: tb/cdx_file_model.sv */
// File register model facing the execution slice
`timescale 1ns/1ps
module cdx_file_model
(
	input  wire logic       clk,
	input  wire logic [6:0] raddr,
	output logic      [7:0] rdata,
	input  wire logic       we,
	input  wire logic [6:0] waddr,
	input  wire logic [7:0] wdata
);
	logic [7:0] mem [128];
	assign rdata = mem[raddr];
	always @(posedge clk)
		if (we)
			mem[waddr] <= wdata;
endmodule : cdx_file_model

/* File: tb/complement_decrement_exec_bench.sv */
// Self-checking bench for the execution slice
`timescale 1ns/1ps
module complement_decrement_exec_bench;
	typedef struct {logic [13:0] i; logic [7:0] v; logic [7:0] r;} cdx_row_t;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic        insn_valid = 1'b0;
	logic [13:0] insn = 14'h0000;
	logic [6:0]  raddr, waddr;
	logic [7:0]  rdata, wdata, acc, status;
	logic        we, done;
	int          error_cnt = 0;
	int          n_tests = 0;
	// Last row leaves acc at 00 for the refusal checks
	cdx_row_t    rows [6] = '{'{14'h0985, 8'h13, 8'hec}, '{14'h097f, 8'hff, 8'h00},
		'{14'h0380, 8'h00, 8'hff}, '{14'h03ff, 8'h80, 8'h7f},
		'{14'h0905, 8'h13, 8'hec}, '{14'h0311, 8'h01, 8'h00}};
	always #2 clk = ~clk;
	cdx_exec dut (.clk(clk), .srst(srst), .insn_valid(insn_valid), .insn(insn),
		.file_raddr(raddr), .file_rdata(rdata), .file_we(we), .file_waddr(waddr),
		.file_wdata(wdata), .acc(acc), .status(status), .op_done(done));
	cdx_file_model regs (.clk(clk), .raddr(raddr), .rdata(rdata), .we(we),
		.waddr(waddr), .wdata(wdata));
	task chk(string nm, logic [7:0] s, logic [7:0] e);
		n_tests++;
		if (s !== e)
		begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task conclude;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : conclude
	initial
	begin
		cdx_row_t r;
		repeat (16) @(negedge clk);
		chk("acc", acc, 8'h00);
		chk("status", status, 8'h18);
		srst = 1'b0;
		@(negedge clk);
		foreach (rows[k])
		begin
			r = rows[k];
			regs.mem[r.i[6:0]] = r.v;
			insn = r.i;
			insn_valid = 1'b1;
			@(negedge clk);
			insn_valid = 1'b0;
			chk("done", 8'(done), 8'h01);
			chk("we", 8'(we), 8'(r.i[7]));
			chk("zero", 8'(status[2]), 8'(r.r == 8'h00));
			chk("flags", status & 8'hfb, 8'h18);
			if (r.i[7])
			begin
				chk("waddr", 8'(waddr), 8'(r.i[6:0]));
				chk("wdata", wdata, r.r);
			end
			else
				chk("acc", acc, r.r);
			@(negedge clk);
			chk("done", 8'(done), 8'h00);
			chk("file", regs.mem[r.i[6:0]], r.i[7] ? r.r : r.v);
			$display("row %0d finished", k);
		end
		regs.mem[7'h11] = 8'h44;
		for (int j = 0; j < 2; j++)
		begin
			insn = j ? 14'h0911 : 14'h0b11;
			insn_valid = !j;
			@(negedge clk);
			chk("done", 8'(done), 8'h00);
			chk("acc", acc, 8'h00);
			chk("status", status, 8'h1c);
		end
		$display("refusal finished");
		regs.mem[7'h30] = 8'h02;
		regs.mem[7'h31] = 8'h0f;
		insn = 14'h03b0;
		insn_valid = 1'b1;
		@(negedge clk);
		insn = 14'h0931;
		chk("done", 8'(done), 8'h01);
		chk("wdata", wdata, 8'h01);
		@(negedge clk);
		insn_valid = 1'b0;
		chk("done", 8'(done), 8'h01);
		chk("we", 8'(we), 8'h00);
		chk("acc", acc, 8'hf0);
		chk("status", status, 8'h18);
		chk("file", regs.mem[7'h30], 8'h01);
		$display("back to back finished");
		regs.mem[7'h22] = 8'h5a;
		insn = 14'h0922;
		insn_valid = 1'b1;
		srst = 1'b1;
		repeat (2) @(negedge clk);
		chk("acc", acc, 8'h00);
		chk("status", status, 8'h18);
		chk("done", 8'(done), 8'h00);
		chk("we", 8'(we), 8'h00);
		srst = 1'b0;
		@(negedge clk);
		insn_valid = 1'b0;
		chk("done", 8'(done), 8'h01);
		chk("acc", acc, 8'ha5);
		chk("status", status, 8'h18);
		@(negedge clk);
		chk("done", 8'(done), 8'h00);
		$display("reset finished");
		conclude;
	end
endmodule : complement_decrement_exec_bench
